//--- logic/charger_input_power_control.sv
// control logic of a buck-boost charger input power path
// assumes one 250 MHz clock and analog status inputs synchronous to it
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "charger_map.svh"
module charger_input_power_control #(
  parameter int unsigned REV_START_CYC = `REV_START_NS * `CLK_MHZ / 1000,
  parameter int unsigned SETTLE_CYC = `SETTLE_UNIT_NS / 1000 * `CLK_MHZ,
  parameter int unsigned INTERVAL_CYC = `INTERVAL_UNIT_NS / 1000 * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic detect_done,
  input wire logic [8:0] detected_limit,
  input wire logic [3:0] detected_source,
  input wire logic dcp_detected,
  input wire logic source_attached,
  input wire logic vdet_done,
  input wire logic vbat_above_minsys,
  input wire logic low_battery_system_status,
  input wire logic bus_present,
  input wire charger_pkg::fault_t faults,
  input wire logic [8:0] current_limit_pin,
  input wire logic input_voltage_regulating,
  input wire logic [7:0] open_circuit_voltage,
  input wire logic light_load,
  input wire logic near_pfm_exit,
  input wire logic bus_below_uvlo,
  input wire logic battery_otg_ok,
  input wire logic thermistor_ok,
  input wire logic input_path1_present,
  input wire logic input_path2_present,
  output logic detect_start,
  output logic switching_enable,
  output logic regulator_enable,
  output logic adc_enable,
  output logic battery_switch_on,
  output logic [8:0] current_limit_out,
  output logic [7:0] voltage_limit_out,
  output logic pfm_active,
  output logic dcm_active,
  output logic audio_floor_on,
  output logic [11:0] peak_current_ma,
  output logic reverse_converter_on,
  output logic [10:0] reverse_voltage_out,
  output logic [6:0] reverse_current_out,
  output logic gate1_drive,
  output logic gate2_drive
);
  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    hit = (a == o);
  endfunction : hit

  function automatic logic [7:0] scale(input logic [7:0] v,
                                       input logic [2:0] r);
    logic [11:0] p;
    // widened first: ratio code 7 plus base is 16 and overflows 4 bits
    p = 12'(v) * (12'(r) + 12'(`RATIO_BASE));
    scale = p[11:4];
  endfunction : scale

  logic rs1_q, rs2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rs2_q);

  // one wait state: read data is loaded at the first edge
  logic ack_q;
  logic [15:0] ctrl_q, ctrl_d, wd;
  logic [8:0] ilim_q, ilim_d, opt_lim_q, eff_lim_q;
  logic [7:0] vlim_q;
  logic [6:0] track_q;
  logic [10:0] rvolt_q;
  logic [6:0] rcur_q;
  logic [3:0] src_q;
  logic [1:0] opt_stat_q;
  logic done_q, bus_ov_q, rev_on_q, settle;
  logic [31:0] rdata;
  charger_pkg::opt_st_t opt_st_q;
  charger_pkg::track_st_t tr_st_q;
  logic [15:0] step_q;
  logic [31:0] tr_cnt_q, rev_cnt_q;

  assign waitrequest = (read | write) & ~ack_q;
  assign wd = writedata[15:0];
  wire wr = write & ack_q;
  wire wr_ctrl = wr & hit(address, `OFS_CTRL);
  wire wr_ilim = wr & hit(address, `OFS_ILIM);
  wire wr_vlim = wr & hit(address, `OFS_VLIM);
  wire wr_track = wr & hit(address, `OFS_TRACK);
  wire wr_rev = wr & hit(address, `OFS_REV);
  wire rd_stat = read & ack_q & hit(address, `OFS_STAT);

  wire [2:0] ex_q = {ctrl_q[`B_TRACK_EN], ctrl_q[`B_VDET], ctrl_q[`B_OPT_EN]};
  wire [2:0] ex_w = {wd[`B_TRACK_EN], wd[`B_VDET], wd[`B_OPT_EN]};
  wire ex_any = |ex_q;
  wire [2:0] ex_ok = ex_q | {3{~ex_any}};
  wire ex0 = ex_w[0] & ex_ok[0];
  wire ex1 = ex_w[1] & ex_ok[1] & ~ex0;
  wire ex2 = ex_w[2] & ex_ok[2] & ~ex0 & ~ex1;
  wire track_block = low_battery_system_status | ~bus_present;
  wire hiz_fault = faults.sys_short | faults.in_ocp;
  wire ov_any = faults.bus_ov | faults.sys_ov | faults.bat_ov | faults.rev_ov;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = wd;
      ctrl_d[`B_OPT_EN] = ex0;
      ctrl_d[`B_VDET] = ex1;
      ctrl_d[`B_TRACK_EN] = ex2;
      ctrl_d[`B_OPT_FORCE] = wd[`B_OPT_FORCE] & ex0;
      // both gates at once is ignored
      if (wd[`B_GATE1] & wd[`B_GATE2]) begin
        ctrl_d[`B_GATE1] = ctrl_q[`B_GATE1];
        ctrl_d[`B_GATE2] = ctrl_q[`B_GATE2];
      end
    end
    if (detect_done & ~wr_ctrl)
      ctrl_d[`B_FORCE_DET] = 1'b0;
    if (vdet_done & ~wr_ctrl)
      ctrl_d[`B_VDET] = 1'b0;
    // force is consumed by the optimizer start one cycle later
    if (ctrl_q[`B_OPT_FORCE] & ~wr_ctrl)
      ctrl_d[`B_OPT_FORCE] = 1'b0;
    if (track_block)
      ctrl_d[`B_TRACK_EN] = 1'b0;
    // system short or input overcurrent fault forces high impedance, wins over host
    if (hiz_fault)
      ctrl_d[`B_HIZ] = 1'b1;
  end

  assign ilim_d = wr_ilim ? writedata[8:0] :
                  detect_done ? detected_limit : ilim_q;

  wire opt_en = ctrl_q[`B_OPT_EN];
  wire hiz_tog = wr_ctrl & (wd[`B_HIZ] != ctrl_q[`B_HIZ]);
  wire retrig = opt_en & (source_attached | dcp_detected | hiz_tog |
                wr_ilim | wr_vlim | ctrl_q[`B_OPT_FORCE] |
                (faults.bus_ov & ~bus_ov_q));

  // tracking timing and scaled voltage limit
  assign settle = (tr_st_q == charger_pkg::TR_SETTLE);
  wire tr_end = (tr_cnt_q == 32'h0);
  wire [31:0] settle_len = 32'(track_q[1:0] + 3'h1) * SETTLE_CYC;
  wire [31:0] run_len = 32'(track_q[6:5] + 3'h1) * INTERVAL_CYC;

  always_ff @(posedge clk or negedge rs2_q) begin
    if (!rs2_q) begin
      ack_q <= 1'b0;
      readdata <= 32'h0;
      ctrl_q <= `RST_CTRL;
      ilim_q <= `RST_ILIM;
      vlim_q <= `RST_VLIM;
      track_q <= `RST_TRACK;
      rvolt_q <= 11'h0;
      rcur_q <= 7'h0;
      src_q <= 4'h0;
      bus_ov_q <= 1'b0;
      detect_start <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
      readdata <= rdata;
      ctrl_q <= ctrl_d;
      ilim_q <= ilim_d;
      if (detect_done)
        src_q <= detected_source;
      if (wr_vlim)
        vlim_q <= writedata[7:0];
      else if (settle & tr_end)
        vlim_q <= scale(open_circuit_voltage, track_q[4:2]);
      if (wr_track)
        track_q <= writedata[6:0];
      if (wr_rev) begin
        rvolt_q <= writedata[10:0];
        rcur_q <= writedata[22:16];
      end
      bus_ov_q <= faults.bus_ov;
      // start detection on the rising command
      detect_start <= ctrl_d[`B_FORCE_DET] & ~ctrl_q[`B_FORCE_DET];
    end
  end

  always_ff @(posedge clk or negedge rs2_q) begin
    if (!rs2_q) begin
      opt_st_q <= charger_pkg::OPT_IDLE;
      opt_stat_q <= `OPT_OFF;
      opt_lim_q <= `START_UP_LIM;
      step_q <= 16'h0;
      done_q <= 1'b0;
    end else begin
      if (rd_stat)
        done_q <= 1'b0;
      step_q <= (step_q == 16'h0) ? `OPT_STEP_CYC : step_q - 16'h1;
      if (!opt_en) begin
        opt_st_q <= charger_pkg::OPT_IDLE;
        opt_stat_q <= `OPT_OFF;
      end else if (retrig) begin
        opt_stat_q <= `OPT_RUN;
        step_q <= `OPT_STEP_CYC;
        opt_st_q <= vbat_above_minsys ? charger_pkg::OPT_UP :
                    charger_pkg::OPT_DOWN;
        opt_lim_q <= vbat_above_minsys ? `START_UP_LIM : ilim_d;
      end else if (step_q == 16'h0) begin
        case (opt_st_q)
          charger_pkg::OPT_UP:
            if (input_voltage_regulating | opt_lim_q >= ilim_q) begin
              opt_st_q <= charger_pkg::OPT_HOLD;
              opt_stat_q <= `OPT_DONE;
              done_q <= 1'b1;
            end else begin
              opt_lim_q <= opt_lim_q + 9'h1;
            end
          charger_pkg::OPT_DOWN:
            if (!input_voltage_regulating | opt_lim_q == 9'h0) begin
              opt_st_q <= charger_pkg::OPT_HOLD;
              opt_stat_q <= `OPT_DONE;
              done_q <= 1'b1;
            end else begin
              opt_lim_q <= opt_lim_q - 9'h1;
            end
          default: ;
        endcase
      end
    end
  end

  wire opt_run = (opt_st_q != charger_pkg::OPT_IDLE);
  wire [8:0] raw_lim = opt_run ? opt_lim_q : ilim_q;
  wire clamp = ctrl_q[`B_EXT_PIN] & (current_limit_pin < raw_lim);
  always_ff @(posedge clk or negedge rs2_q) begin
    if (!rs2_q)
      eff_lim_q <= `RST_ILIM;
    else
      eff_lim_q <= clamp ? current_limit_pin : raw_lim;
  end
  assign current_limit_out = eff_lim_q;
  assign voltage_limit_out = vlim_q;

  always_ff @(posedge clk or negedge rs2_q) begin
    if (!rs2_q) begin
      tr_st_q <= charger_pkg::TR_OFF;
      tr_cnt_q <= 32'h0;
    end else if (!ctrl_q[`B_TRACK_EN]) begin
      tr_st_q <= charger_pkg::TR_OFF;
      tr_cnt_q <= 32'h0;
    end else begin
      tr_cnt_q <= tr_cnt_q - 32'h1;
      case (tr_st_q)
        charger_pkg::TR_OFF: begin
          tr_st_q <= charger_pkg::TR_SETTLE;
          tr_cnt_q <= settle_len;
        end
        charger_pkg::TR_SETTLE:
          if (tr_end) begin
            tr_st_q <= charger_pkg::TR_RUN;
            tr_cnt_q <= run_len;
          end
        charger_pkg::TR_RUN:
          if (tr_end) begin
            tr_st_q <= charger_pkg::TR_SETTLE;
            tr_cnt_q <= settle_len;
          end
        default: tr_st_q <= charger_pkg::TR_OFF;
      endcase
    end
  end

  wire high_impedance_state = ctrl_q[`B_HIZ];
  wire rev_en = ctrl_q[`B_REV_EN];
  wire gates_off = ctrl_q[`B_GATES_OFF];
  wire g1 = ctrl_q[`B_GATE1] & input_path1_present & ~gates_off;
  wire g2 = ctrl_q[`B_GATE2] & input_path2_present & ~gates_off;
  wire no_paths = gates_off | ~(input_path1_present | input_path2_present);
  wire rev_ok = battery_otg_ok & thermistor_ok & ~faults.bat_ov;
  wire rev_arm = rev_on_q | bus_below_uvlo;
  always_ff @(posedge clk or negedge rs2_q) begin
    if (!rs2_q) begin
      rev_on_q <= 1'b0;
      rev_cnt_q <= 32'h0;
    end else if (!rev_en | high_impedance_state | !rev_ok | !rev_arm) begin
      rev_on_q <= 1'b0;
      rev_cnt_q <= 32'h0;
    end else if (no_paths) begin
      if (rev_cnt_q == REV_START_CYC)
        rev_on_q <= 1'b1;
      else
        rev_cnt_q <= rev_cnt_q + 32'h1;
    end else begin
      // host clears one gate before setting the other
      rev_on_q <= g1 | g2;
    end
  end

  wire skip_dis = rev_on_q ? ctrl_q[`B_REV_SKIP] : ctrl_q[`B_FWD_SKIP];
  wire aud_dis = rev_on_q ? ctrl_q[`B_REV_AUD] : ctrl_q[`B_FWD_AUD];
  wire fwd_go = ~rev_en & bus_present;
  // high impedance and overvoltage stop switching
  wire sw_d = ~high_impedance_state & ~ov_any & ~settle & (rev_on_q | fwd_go);
  wire pfm_d = light_load & ~skip_dis & sw_d;
  wire floor_d = pfm_d & ~aud_dis;
  always_ff @(posedge clk or negedge rs2_q) begin
    if (!rs2_q) begin
      switching_enable <= 1'b0;
      regulator_enable <= 1'b0;
      adc_enable <= 1'b0;
      battery_switch_on <= 1'b0;
      pfm_active <= 1'b0;
      dcm_active <= 1'b0;
      audio_floor_on <= 1'b0;
      peak_current_ma <= `PEAK_HIGH_MA;
      gate1_drive <= 1'b0;
      gate2_drive <= 1'b0;
    end else begin
      switching_enable <= sw_d;
      regulator_enable <= ~high_impedance_state;
      adc_enable <= ~high_impedance_state | ctrl_q[`B_MEAS];
      battery_switch_on <= high_impedance_state;
      pfm_active <= pfm_d;
      dcm_active <= light_load & skip_dis & sw_d;
      audio_floor_on <= floor_d;
      peak_current_ma <= (floor_d & ~near_pfm_exit) ? `PEAK_LOW_MA :
                         `PEAK_HIGH_MA;
      gate1_drive <= g1;
      gate2_drive <= g2;
    end
  end
  assign reverse_converter_on = rev_on_q;
  assign reverse_voltage_out = rvolt_q;
  assign reverse_current_out = rcur_q;

  assign rdata = hit(address, `OFS_CTRL) ? {16'h0, ctrl_q} :
                 hit(address, `OFS_ILIM) ? {23'h0, ilim_q} :
                 hit(address, `OFS_VLIM) ? {24'h0, vlim_q} :
                 hit(address, `OFS_TRACK) ? {25'h0, track_q} :
                 hit(address, `OFS_REV) ? {9'h0, rcur_q, 5'h0, rvolt_q} :
                 hit(address, `OFS_STAT) ? {15'h0, rev_on_q, src_q,
                   done_q, opt_stat_q, eff_lim_q} : 32'h0;

  property p_det_clear;
    ctrl_q[`B_FORCE_DET] && detect_done && !wr_ctrl
      |=> !ctrl_q[`B_FORCE_DET];
  endproperty
  a_det_clear: assert property (p_det_clear)
    else $error("force detect did not clear");
  property p_opt_off;
    !opt_en ##1 !opt_en |-> opt_stat_q == `OPT_OFF && !opt_run;
  endproperty
  a_opt_off: assert property (p_opt_off)
    else $error("optimizer active while disabled");
  property p_up_start;
    retrig && vbat_above_minsys |=> opt_lim_q == `START_UP_LIM
      && opt_st_q == charger_pkg::OPT_UP;
  endproperty
  a_up_start: assert property (p_up_start)
    else $error("upward search start wrong");
  property p_down_start;
    retrig && !vbat_above_minsys |=> opt_lim_q == ilim_q;
  endproperty
  a_down_start: assert property (p_down_start)
    else $error("downward search start wrong");
  property p_hold;
    opt_st_q == charger_pkg::OPT_HOLD && !retrig && opt_en
      |=> $stable(opt_lim_q) && opt_stat_q == `OPT_DONE;
  endproperty
  a_hold: assert property (p_hold)
    else $error("held limit moved");
  property p_retrig;
    retrig |=> opt_stat_q == `OPT_RUN;
  endproperty
  a_retrig: assert property (p_retrig)
    else $error("retrigger did not reset state");
  property p_track_block;
    track_block |=> !ctrl_q[`B_TRACK_EN];
  endproperty
  a_track_block: assert property (p_track_block)
    else $error("tracking enabled while blocked");
  property p_excl;
    $onehot0(ex_q);
  endproperty
  a_excl: assert property (p_excl)
    else $error("exclusive enables both set");
  property p_hiz_fault;
    faults.sys_short |=> high_impedance_state ##1 !regulator_enable && !switching_enable;
  endproperty
  a_hiz_fault: assert property (p_hiz_fault)
    else $error("short fault did not force high impedance");
  property p_rev_delay;
    $rose(rev_on_q) && $past(no_paths) |-> rev_cnt_q == REV_START_CYC;
  endproperty
  a_rev_delay: assert property (p_rev_delay)
    else $error("reverse start before delay");
endmodule : charger_input_power_control
`default_nettype wire

//--- pkg/charger_map.svh
// register offsets, field positions, reset values and timing figures
// included by the control logic, its bench and the host bus model
`ifndef CHARGER_MAP_SVH
`define CHARGER_MAP_SVH
`define OFS_CTRL 5'h00
`define OFS_ILIM 5'h04
`define OFS_VLIM 5'h08
`define OFS_TRACK 5'h0C
`define OFS_REV 5'h10
`define OFS_STAT 5'h14
`define B_FORCE_DET 0
`define B_OPT_EN 1
`define B_OPT_FORCE 2
`define B_EXT_PIN 3
`define B_TRACK_EN 4
`define B_VDET 5
`define B_HIZ 6
`define B_MEAS 7
`define B_FWD_SKIP 8
`define B_FWD_AUD 9
`define B_REV_SKIP 10
`define B_REV_AUD 11
`define B_REV_EN 12
`define B_GATES_OFF 13
`define B_GATE1 14
`define B_GATE2 15
`define RST_CTRL 16'h0008
`define RST_ILIM 9'h12C
`define RST_VLIM 8'h24
`define RST_TRACK 7'h00
`define START_UP_LIM 9'h032
`define RATIO_BASE 4'h9
`define OPT_OFF 2'h0
`define OPT_RUN 2'h1
`define OPT_DONE 2'h2
`define OPT_STEP_CYC 16'h0100
`define PEAK_LOW_MA 12'h7D0
`define PEAK_HIGH_MA 12'hCE4
`define CLK_MHZ 250
`define REV_START_NS 5000000
`define SETTLE_UNIT_NS 50000000
`define INTERVAL_UNIT_NS 1000000000
`endif

//--- pkg/charger_pkg.sv
// types shared by the control logic and its bench
// assumes nothing beyond a SystemVerilog compiler
package charger_pkg;
  typedef enum logic [1:0] {OPT_IDLE, OPT_UP, OPT_DOWN, OPT_HOLD} opt_st_t;
  typedef enum logic [1:0] {TR_OFF, TR_SETTLE, TR_RUN} track_st_t;
  typedef struct packed {
    logic bus_ov;
    logic sys_ov;
    logic bat_ov;
    logic rev_ov;
    logic sys_short;
    logic in_ocp;
  } fault_t;
endpackage : charger_pkg

//--- tb/charger_input_power_control_bench.sv
// self-checking bench for the charger input power control block
// assumes host_bus_model on the register bus; status inputs driven here
`timescale 1ns/10ps
`default_nettype none
`include "charger_map.svh"
module charger_input_power_control_bench;
  logic clk, rst_n, read, write, waitrequest, hang, det_done, dcp;
  logic vbat_hi, low_bat, bus_pres, regulating, light, near_exit, bus_low;
  logic bat_ok, therm_ok, path1, path2, det_start, sw_en, reg_en, adc_en;
  logic bat_sw, pulse_frequency_mode, dcm, floor_on, rev_on, g1, g2, attach, vdone;
  logic [4:0] address;
  logic [31:0] writedata, readdata, rdv;
  logic [8:0] det_lim, pin_lim, ilim_out, lim;
  logic [3:0] det_src;
  logic [7:0] voc, vlim_out;
  logic [11:0] peak;
  logic [10:0] rev_v, v;
  logic [6:0] rev_c, c;
  logic [2:0] r;
  charger_pkg::fault_t faults;
  int n_errors, total_checks, n_start, i, seed;

  host_bus_model host (.clk(clk), .waitrequest(waitrequest),
    .readdata(readdata), .address(address), .read(read), .write(write),
    .writedata(writedata), .hang(hang));

  charger_input_power_control #(.REV_START_CYC(20), .SETTLE_CYC(10),
    .INTERVAL_CYC(30)) dut (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .detect_done(det_done),
    .detected_limit(det_lim), .detected_source(det_src),
    .dcp_detected(dcp), .source_attached(attach), .vdet_done(vdone),
    .vbat_above_minsys(vbat_hi), .low_battery_system_status(low_bat),
    .bus_present(bus_pres), .faults(faults), .current_limit_pin(pin_lim),
    .input_voltage_regulating(regulating), .open_circuit_voltage(voc),
    .light_load(light), .near_pfm_exit(near_exit), .bus_below_uvlo(bus_low),
    .battery_otg_ok(bat_ok), .thermistor_ok(therm_ok),
    .input_path1_present(path1), .input_path2_present(path2),
    .detect_start(det_start), .switching_enable(sw_en),
    .regulator_enable(reg_en), .adc_enable(adc_en),
    .battery_switch_on(bat_sw), .current_limit_out(ilim_out),
    .voltage_limit_out(vlim_out), .pfm_active(pulse_frequency_mode), .dcm_active(dcm),
    .audio_floor_on(floor_on), .peak_current_ma(peak),
    .reverse_converter_on(rev_on), .reverse_voltage_out(rev_v),
    .reverse_current_out(rev_c), .gate1_drive(g1), .gate2_drive(g2));

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic rchk(input string s, input logic [4:0] a,
                      input logic [31:0] m, input logic [31:0] e);
    host.rd(a, rdv);
    chk(s, e & m, rdv & m);
  endtask : rchk

  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic pulse_dcp;
    dcp <= 1'b1;
    @(posedge clk);
    dcp <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_dcp

  // bounded wait for the switching enable to reach a level
  task automatic wait_sw(input logic v);
    int n;
    n = 0;
    while (sw_en !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      n_errors++;
      test_done();
    end
  endtask : wait_sw

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard for the whole run
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    test_done();
  end

  always @(posedge clk) begin
    if (det_start === 1'b1) n_start++;
    if (hang === 1'b1) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    seed = $urandom(2583);
    rst_n = 1'b0;
    {det_done, dcp, low_bat, regulating, light, near_exit, attach, vdone} = '0;
    {bus_low, bat_ok, therm_ok, path1, path2, det_lim, det_src} = '0;
    {vbat_hi, bus_pres, voc, faults} = '0;
    vbat_hi = 1'b1;
    bus_pres = 1'b1;
    pin_lim = 9'h1FF;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk("ctrl", `OFS_CTRL, 32'hFFFF, 32'h0008);
    rchk("ilim", `OFS_ILIM, 32'h1FF, 32'h12C);
    chk("regulator", 1, reg_en);
    chk("adc", 1, adc_en);
    chk("switching", 1, sw_en);
    // kept above the 500 mA start so the upward search has room
    det_lim <= 9'($urandom_range(511, 64));
    det_src <= 4'($urandom);
    host.wr(`OFS_CTRL, 32'h0009);
    rchk("detect busy", `OFS_CTRL, 32'h1, 32'h1);
    chk("detect start", 1, n_start);
    det_done <= 1'b1;
    @(posedge clk);
    det_done <= 1'b0;
    repeat (2) @(posedge clk);
    rchk("detect clear", `OFS_CTRL, 32'h1, 32'h0);
    rchk("detect limit", `OFS_ILIM, 32'h1FF, {23'h0, det_lim});
    rchk("detect source", `OFS_STAT, 32'hF000, {det_src, 12'h0});
    pulse_dcp();
    rchk("opt off", `OFS_STAT, 32'h600, 32'h000);
    host.wr(`OFS_CTRL, 32'h000A);
    pulse_dcp();
    rchk("opt dcp", `OFS_STAT, 32'h600, 32'h200);
    host.wr(`OFS_CTRL, 32'h000E);
    repeat (2) @(posedge clk);
    chk("opt start", 9'h032, ilim_out);
    repeat (600) @(posedge clk);
    chk("opt up", 1, ilim_out > 9'h032);
    regulating <= 1'b1;
    repeat (300) @(posedge clk);
    rchk("opt done", `OFS_STAT, 32'hE00, 32'hC00);
    lim = ilim_out;
    repeat (600) @(posedge clk);
    chk("opt hold", lim, ilim_out);
    vbat_hi <= 1'b0;
    host.wr(`OFS_ILIM, 32'h0C8);
    repeat (2) @(posedge clk);
    chk("opt restart", 9'h0C8, ilim_out);
    rchk("opt rerun", `OFS_STAT, 32'h600, 32'h200);
    repeat (600) @(posedge clk);
    chk("opt down", 1, ilim_out < 9'h0C8);
    regulating <= 1'b0;
    repeat (300) @(posedge clk);
    rchk("opt found", `OFS_STAT, 32'h600, 32'h400);
    attach <= 1'b1;
    @(posedge clk);
    attach <= 1'b0;
    rchk("opt attach", `OFS_STAT, 32'h600, 32'h200);
    for (i = 4; i < 6; i++) begin
      host.wr(`OFS_CTRL, 32'h000A | (32'h1 << i));
      rchk("exclusive", `OFS_CTRL, 32'h0032, 32'h0002);
    end
    host.wr(`OFS_CTRL, 32'h0008);
    host.wr(`OFS_CTRL, 32'h0028);
    host.wr(`OFS_CTRL, 32'h003A);
    rchk("vdet excl", `OFS_CTRL, 32'h32, 32'h20);
    vdone <= 1'b1;
    @(posedge clk);
    vdone <= 1'b0;
    rchk("vdet clear", `OFS_CTRL, 32'h20, 32'h0);
    host.wr(`OFS_ILIM, 32'h100);
    pin_lim <= 9'h040;
    repeat (3) @(posedge clk);
    chk("pin clamp", 9'h040, ilim_out);
    host.wr(`OFS_CTRL, 32'h0000);
    repeat (2) @(posedge clk);
    chk("pin free", 9'h100, ilim_out);
    low_bat <= 1'b1;
    host.wr(`OFS_CTRL, 32'h0010);
    rchk("track refused", `OFS_CTRL, 32'h10, 32'h0);
    low_bat <= 1'b0;
    r = 3'($urandom);
    voc <= 8'($urandom);
    host.wr(`OFS_TRACK, {27'h0, r, 2'b00});
    host.wr(`OFS_CTRL, 32'h0010);
    repeat (2) @(posedge clk);
    chk("settle stop", 0, sw_en);
    rchk("track on", `OFS_CTRL, 32'h10, 32'h10);
    for (int k = 0; k < 2; k++) begin
      wait_sw(1'b1);
      repeat (2) @(posedge clk);
      chk("vlim", ((9 + r) * voc) >> 4, vlim_out);
      voc <= 8'($urandom);
      wait_sw(1'b0);
    end
    bus_pres <= 1'b0;
    repeat (3) @(posedge clk);
    rchk("track drop", `OFS_CTRL, 32'h10, 32'h0);
    host.wr(`OFS_CTRL, 32'h0010);
    rchk("track held", `OFS_CTRL, 32'h10, 32'h0);
    bus_pres <= 1'b1;
    light <= 1'b1;
    for (i = 0; i < 4; i++) begin
      host.wr(`OFS_CTRL, 32'(i) << 8);
      repeat (3) @(posedge clk);
      chk("pfm", !i[0], pulse_frequency_mode);
      chk("dcm", i[0], dcm);
      chk("floor", i == 0, floor_on);
      if (!i[0]) chk("peak", i == 0 ? 2000 : 3300, peak);
    end
    near_exit <= 1'b1;
    host.wr(`OFS_CTRL, 32'h0000);
    repeat (3) @(posedge clk);
    chk("peak exit", 3300, peak);
    {light, near_exit} <= 2'b00;
    host.wr(`OFS_CTRL, 32'h0040);
    repeat (3) @(posedge clk);
    chk("hiz", 32'h1, {reg_en, sw_en, adc_en, bat_sw});
    host.wr(`OFS_CTRL, 32'h00C0);
    repeat (3) @(posedge clk);
    chk("hiz adc", 1, adc_en);
    for (i = 0; i < 6; i++) begin
      host.wr(`OFS_CTRL, 32'h0000);
      repeat (10) @(posedge clk);
      faults <= charger_pkg::fault_t'(6'h1 << i);
      repeat (3) @(posedge clk);
      chk("fault stop", 0, sw_en);
      chk("fault ldo", i > 1, reg_en);
      rchk("fault hiz", `OFS_CTRL, 32'h40, 32'(i < 2) << 6);
      faults <= '0;
    end
    host.wr(`OFS_CTRL, 32'h0000);
    v = 11'($urandom);
    c = 7'($urandom);
    host.wr(`OFS_REV, {9'h0, c, 5'h0, v});
    chk("rev volt", v, rev_v);
    chk("rev cur", c, rev_c);
    bus_low <= 1'b1;
    host.wr(`OFS_CTRL, 32'h1000);
    repeat (40) @(posedge clk);
    chk("rev no bat", 0, rev_on);
    host.wr(`OFS_CTRL, 32'h0000);
    {bat_ok, therm_ok} <= 2'b11;
    host.wr(`OFS_CTRL, 32'h1000);
    repeat (10) @(posedge clk);
    chk("rev early", 0, rev_on);
    repeat (20) @(posedge clk);
    chk("rev start", 1, rev_on);
    host.wr(`OFS_CTRL, 32'h0000);
    {path1, path2} <= 2'b11;
    host.wr(`OFS_CTRL, 32'h1000);
    repeat (40) @(posedge clk);
    chk("rev gated", 0, rev_on);
    host.wr(`OFS_CTRL, 32'h5000);
    repeat (40) @(posedge clk);
    chk("rev gate1", 32'h5, {rev_on, g2, g1});
    host.wr(`OFS_CTRL, 32'hD000);
    rchk("both gates", `OFS_CTRL, 32'hC000, 32'h4000);
    host.move_reverse(32'h1000, `B_GATE2);
    repeat (40) @(posedge clk);
    chk("rev gate2", 32'h6, {rev_on, g2, g1});
    host.wr(`OFS_CTRL, 32'h0000);
    host.wr(`OFS_CTRL, 32'h3000);
    repeat (30) @(posedge clk);
    chk("rev forced", 32'h4, {rev_on, g2, g1});
    test_done();
  end
endmodule : charger_input_power_control_bench
`default_nettype wire

//--- tb/host_bus_model.sv
// host side of the register bus: Avalon-MM master with waitrequest
// assumes the slave lowers waitrequest within 64 cycles of a request
`timescale 1ns/10ps
`default_nettype none
`include "charger_map.svh"
module host_bus_model (
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [4:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic hang
);
  initial begin
    {address, read, write, writedata, hang} = '0;
  end

  // request held until waitrequest is sampled low
  task automatic finish_req;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    if (n >= 64) hang <= 1'b1;
  endtask : finish_req

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    finish_req();
    write <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    address <= a;
    read <= 1'b1;
    finish_req();
    d = readdata;
    read <= 1'b0;
    @(posedge clk);
  endtask : rd

  // gate off, wait, other gate on
  task automatic move_reverse(input logic [31:0] base, input int to_bit);
    wr(`OFS_CTRL, base);
    repeat (40) @(posedge clk);
    wr(`OFS_CTRL, base | (32'h1 << to_bit));
  endtask : move_reverse
endmodule : host_bus_model
`default_nettype wire
